// file: tpa_aligner.sv
// transmit pointer aligner: add bus capture, elastic store, pointer
// regeneration with justification, byte rewriting and apb registers
// assumes add bus pins change after the rising edge of the add clock and
// a transmit slot strobe that comes from the reference clock domain
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
module tpa_aligner (
  input logic i_ref_clk,
  input logic i_resetn,
  input tpa_pkg::tpa_apb_req_t i_apb,
  output tpa_pkg::tpa_apb_rsp_t o_apb,
  input logic i_add_clk,
  input tpa_pkg::tpa_add_bus_t i_add_bus,
  input tpa_pkg::tpa_tx_slot_t i_tx_slot,
  output tpa_pkg::tpa_tx_out_t o_tx,
  output logic o_interrupt_out_n
);

  typedef struct packed {
    logic [2:0] clk_sync;
    tpa_pkg::tpa_add_bus_t bus_s1;
    tpa_pkg::tpa_add_bus_t bus_s2;
    logic [7:0] indicator_a_low;
    logic [7:0] indicator_a_high;
    logic [7:0] control;
    logic [7:0] status_cfg;
    logic [1:0] stream_mode;
    logic pos_justify_status;
    logic neg_justify_status;
    logic fifo_error_status;
    logic sf_change;
    logic sf_state;
    tpa_pkg::tpa_js_t js;
    logic js_pos;
    logic [3:0] frame_cnt;
    logic [9:0] ptr;
    logic [1:0] h4_phase;
    logic primed;
    tpa_pkg::tpa_apb_rsp_t apb;
    logic irq_n;
    tpa_pkg::tpa_tx_out_t tx;
  } tpa_aligner_st_t;

  tpa_aligner_st_t st_r;
  tpa_aligner_st_t st_nxt;

  tpa_pkg::tpa_fifo_word_t fifo_wdata;
  tpa_pkg::tpa_fifo_word_t fifo_rdata;
  logic [5:0] fifo_fill;
  logic fifo_push;
  logic fifo_pop;

  // register decode shared by the read mux and the write path
  function automatic logic reg_hit(input logic [tpa_pkg::APB_AW-1:0] addr,
                                   input logic [7:0] idx);
    reg_hit = (addr[tpa_pkg::APB_AW-1:2] == {2'h0, idx});
  endfunction

  function automatic logic addr_mapped(input logic [tpa_pkg::APB_AW-1:0] addr);
    addr_mapped = reg_hit(addr, tpa_pkg::IDX_INDICATOR_A_LOW) ||
                  reg_hit(addr, tpa_pkg::IDX_INDICATOR_A_HIGH) ||
                  reg_hit(addr, tpa_pkg::IDX_CONTROL) ||
                  reg_hit(addr, tpa_pkg::IDX_STATUS_DIAG) ||
                  reg_hit(addr, tpa_pkg::IDX_SIGNAL_FAIL) ||
                  reg_hit(addr, tpa_pkg::IDX_STREAM_MODE);
  endfunction

  tpa_fifo u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_push(fifo_push),
    .i_wdata(fifo_wdata),
    .i_pop(fifo_pop),
    .o_rdata(fifo_rdata),
    .o_fill(fifo_fill)
  );

  // add bus capture: the add clock is only sampled, and data is taken on
  // its falling edge, half a link period after the pins last changed
  logic add_fall;
  logic add_is_v1;
  assign add_fall = st_r.clk_sync[2] && !st_r.clk_sync[1];
  assign add_is_v1 = st_r.bus_s2.marker && (st_r.bus_s2.slot == tpa_pkg::SLOT_H4);
  assign fifo_push = add_fall && tpa_pkg::tpa_carries_payload(st_r.bus_s2.slot);
  always_comb begin
    fifo_wdata.is_v1 = add_is_v1;
    fifo_wdata.is_h4 = (st_r.bus_s2.slot == tpa_pkg::SLOT_H4);
    fifo_wdata.is_fstuff = (st_r.bus_s2.slot == tpa_pkg::SLOT_FSTUFF);
    fifo_wdata.data = st_r.bus_s2.data;
  end

  // configuration views
  tpa_pkg::tpa_diag_t diag;
  tpa_pkg::tpa_limits_t lim;
  logic [5:0] fill_over;
  logic [5:0] fill_under;
  logic want_pos;
  logic want_neg;
  logic frame_start;
  logic just_here;
  logic diag_auto;

  assign diag = tpa_pkg::tpa_diag_t'(st_r.status_cfg[tpa_pkg::STS_DIAG_LSB +: 2]);
  assign lim = tpa_pkg::tpa_limits(st_r.status_cfg[tpa_pkg::STS_DEPTH_LSB +: 2]);
  assign diag_auto = (diag == tpa_pkg::DIAG_AUTO);
  assign fill_over = (fifo_fill > tpa_pkg::FIFO_CENTRE) ? fifo_fill - tpa_pkg::FIFO_CENTRE
                                                        : 6'h00;
  assign fill_under = (fifo_fill < tpa_pkg::FIFO_CENTRE) ? tpa_pkg::FIFO_CENTRE - fifo_fill
                                                         : 6'h00;

  // justification choice; the 4-frame spacing comes from the state loop,
  // the 16-frame soft rate from the frame counter wrapping
  always_comb begin
    want_pos = 1'b0;
    want_neg = 1'b0;
    unique case (diag)
      tpa_pkg::DIAG_POS: want_pos = 1'b1;
      tpa_pkg::DIAG_NEG: want_neg = 1'b1;
      tpa_pkg::DIAG_NONE: begin
        want_pos = 1'b0;
        want_neg = 1'b0;
      end
      tpa_pkg::DIAG_AUTO: begin
        want_neg = (fill_over > {3'h0, lim.hard_neg}) ||
                   ((fill_over > {3'h0, lim.soft_neg}) &&
                    (st_r.frame_cnt == tpa_pkg::FRAME_CNT_RST));
        want_pos = (fill_under > {3'h0, lim.hard_pos}) ||
                   ((fill_under > {3'h0, lim.soft_pos}) &&
                    (st_r.frame_cnt == tpa_pkg::FRAME_CNT_RST));
      end
    endcase
  end

  assign frame_start = i_tx_slot.valid && (i_tx_slot.slot == tpa_pkg::SLOT_H1) &&
                       (i_tx_slot.sts == 2'h0);
  assign just_here = (st_r.js == tpa_pkg::JS_JUST) && (i_tx_slot.sts == 2'h0);

  // transmit read side: h3 carries data on a negative event, the byte after
  // h3 is left empty on a positive one
  always_comb begin
    fifo_pop = 1'b0;
    if (i_tx_slot.valid && st_r.primed) begin
      if (tpa_pkg::tpa_carries_payload(i_tx_slot.slot)) begin
        fifo_pop = 1'b1;
      end else if (i_tx_slot.slot == tpa_pkg::SLOT_PJO) begin
        fifo_pop = !(just_here && st_r.js_pos);
      end else if (i_tx_slot.slot == tpa_pkg::SLOT_H3) begin
        fifo_pop = just_here && !st_r.js_pos;
      end
    end
  end

  logic overflow;
  logic underflow;
  assign overflow = fifo_push && (fifo_fill == tpa_pkg::FIFO_FULL);
  assign underflow = fifo_pop && (fifo_fill == 6'h00);

  logic [9:0] ptr_tx;
  logic indicator_a_slot;
  logic [7:0] rd_access;
  logic [7:0] status_view;
  logic [7:0] sf_view;
  logic access_done;
  logic isf_now;

  assign ptr_tx = st_r.ptr ^ ((st_r.js == tpa_pkg::JS_JUST) ?
                  (st_r.js_pos ? tpa_pkg::PTR_I_MASK : tpa_pkg::PTR_D_MASK) : 10'h000);
  assign indicator_a_slot = (st_r.stream_mode == tpa_pkg::MODE_STS3C) &&
                       (i_tx_slot.sts != 2'h0);
  assign status_view = st_r.status_cfg |
                       {4'h0, st_r.fifo_error_status, st_r.pos_justify_status,
                        st_r.neg_justify_status, 1'b0};
  assign sf_view = {st_r.sf_state, st_r.sf_change, 6'h00};
  assign access_done = i_apb.psel && i_apb.penable && st_r.apb.pready;
  assign isf_now = (st_r.bus_s2.data[3:0] == tpa_pkg::ISF_CODE);

  always_comb begin
    rd_access = 8'h00;
    if (reg_hit(i_apb.paddr, tpa_pkg::IDX_INDICATOR_A_LOW)) rd_access = st_r.indicator_a_low;
    if (reg_hit(i_apb.paddr, tpa_pkg::IDX_INDICATOR_A_HIGH)) rd_access = st_r.indicator_a_high;
    if (reg_hit(i_apb.paddr, tpa_pkg::IDX_CONTROL)) rd_access = st_r.control;
    if (reg_hit(i_apb.paddr, tpa_pkg::IDX_STATUS_DIAG)) rd_access = status_view;
    if (reg_hit(i_apb.paddr, tpa_pkg::IDX_SIGNAL_FAIL)) rd_access = sf_view;
    if (reg_hit(i_apb.paddr, tpa_pkg::IDX_STREAM_MODE)) begin
      rd_access = {6'h00, st_r.stream_mode};
    end
  end

  always_comb begin
    st_nxt = st_r;
    // three-flop chain for the add clock and two-flop synchronisers for the add bus pins
    st_nxt.clk_sync = {st_r.clk_sync[1], st_r.clk_sync[0], i_add_clk};
    st_nxt.bus_s1 = i_add_bus;
    st_nxt.bus_s2 = st_r.bus_s1;

    if (fifo_fill >= tpa_pkg::FIFO_CENTRE) begin
      st_nxt.primed = 1'b1;
    end

    // transmit byte
    st_nxt.tx.valid = i_tx_slot.valid;
    st_nxt.tx.data = 8'h00;
    if (i_tx_slot.valid) begin
      unique case (i_tx_slot.slot)
        tpa_pkg::SLOT_H1: begin
          st_nxt.tx.data = indicator_a_slot ? st_r.indicator_a_high
                         : {tpa_pkg::PTR_NDF_NORMAL, 2'h0, ptr_tx[9:8]};
        end
        tpa_pkg::SLOT_H2: begin
          st_nxt.tx.data = indicator_a_slot ? st_r.indicator_a_low : ptr_tx[7:0];
        end
        tpa_pkg::SLOT_TOH: st_nxt.tx.data = 8'h00;
        default: begin
          if (fifo_pop) begin
            st_nxt.tx.data = fifo_rdata.data;
            if (fifo_rdata.is_fstuff && st_r.control[tpa_pkg::CTL_CLEAR_STUFF]) begin
              st_nxt.tx.data = 8'h00;
            end
            if (fifo_rdata.is_h4) begin
              st_nxt.h4_phase = fifo_rdata.is_v1 ? 2'h1 : st_r.h4_phase + 2'h1;
              if (!st_r.control[tpa_pkg::CTL_MF_BYPASS]) begin
                st_nxt.tx.data = tpa_pkg::H4_SEQ_BASE |
                  {6'h00, fifo_rdata.is_v1 ? 2'h0 : st_r.h4_phase};
              end else begin
                st_nxt.tx.data = fifo_rdata.data;
              end
            end
          end
        end
      endcase
    end

    // pointer action sequence, one step per transmit frame
    if (frame_start) begin
      st_nxt.frame_cnt = st_r.frame_cnt + 4'h1;
      unique case (st_r.js)
        tpa_pkg::JS_NORMAL: begin
          if (want_pos || want_neg) begin
            st_nxt.js = tpa_pkg::JS_JUST;
            st_nxt.js_pos = want_pos;
          end
        end
        tpa_pkg::JS_JUST: begin
          st_nxt.js = tpa_pkg::JS_SETTLE;
          if (st_r.js_pos) begin
            st_nxt.ptr = (st_r.ptr == tpa_pkg::PTR_MAX) ? 10'h000 : st_r.ptr + 10'h001;
          end else begin
            st_nxt.ptr = (st_r.ptr == 10'h000) ? tpa_pkg::PTR_MAX : st_r.ptr - 10'h001;
          end
        end
        tpa_pkg::JS_SETTLE: st_nxt.js = tpa_pkg::JS_COOL;
        tpa_pkg::JS_COOL: st_nxt.js = tpa_pkg::JS_NORMAL;
      endcase
    end

    // apb: answer registered at setup, so pready is high in the first
    // access cycle; writes and read clears act at the completing edge
    st_nxt.apb.pready = 1'b0;
    st_nxt.apb.pslverr = 1'b0;
    st_nxt.apb.prdata = 32'h0000_0000;
    if (i_apb.psel && !i_apb.penable) begin
      st_nxt.apb.pready = 1'b1;
      st_nxt.apb.pslverr = !addr_mapped(i_apb.paddr);
      st_nxt.apb.prdata = i_apb.pwrite ? 32'h0000_0000 : {24'h00_0000, rd_access};
    end
    if (access_done && i_apb.pwrite) begin
      if (reg_hit(i_apb.paddr, tpa_pkg::IDX_INDICATOR_A_LOW)) begin
        st_nxt.indicator_a_low = i_apb.pwdata[7:0];
      end
      if (reg_hit(i_apb.paddr, tpa_pkg::IDX_INDICATOR_A_HIGH)) begin
        st_nxt.indicator_a_high = i_apb.pwdata[7:0];
      end
      // reserved bits are stored as written; software sets them right
      if (reg_hit(i_apb.paddr, tpa_pkg::IDX_CONTROL)) begin
        st_nxt.control = i_apb.pwdata[7:0];
      end
      if (reg_hit(i_apb.paddr, tpa_pkg::IDX_STATUS_DIAG)) begin
        st_nxt.status_cfg = i_apb.pwdata[7:0] & tpa_pkg::STATUS_DIAG_RW_MASK;
      end
      if (reg_hit(i_apb.paddr, tpa_pkg::IDX_STREAM_MODE)) begin
        st_nxt.stream_mode = i_apb.pwdata[1:0];
      end
    end
    if (access_done && !i_apb.pwrite) begin
      if (reg_hit(i_apb.paddr, tpa_pkg::IDX_STATUS_DIAG)) begin
        st_nxt.pos_justify_status = 1'b0;
        st_nxt.neg_justify_status = 1'b0;
        st_nxt.fifo_error_status = 1'b0;
      end
      if (reg_hit(i_apb.paddr, tpa_pkg::IDX_SIGNAL_FAIL)) begin
        st_nxt.sf_change = 1'b0;
      end
    end

    // status events come after the clears so that a same-cycle event wins
    if (frame_start && (st_r.js == tpa_pkg::JS_NORMAL)) begin
      if (want_pos) begin
        st_nxt.pos_justify_status = 1'b1;
      end else if (want_neg) begin
        st_nxt.neg_justify_status = 1'b1;
      end
    end
    if ((overflow || underflow) && diag_auto) begin
      st_nxt.fifo_error_status = 1'b1;
    end
    if (fifo_push && (st_r.bus_s2.slot == tpa_pkg::SLOT_Z5) &&
        (isf_now != st_r.sf_state)) begin
      st_nxt.sf_state = isf_now;
      st_nxt.sf_change = 1'b1;
    end

    st_nxt.irq_n = !(
      ((st_nxt.pos_justify_status || st_nxt.neg_justify_status) &&
       st_r.control[tpa_pkg::CTL_PJ_IRQ_EN]) ||
      (st_nxt.fifo_error_status && st_r.control[tpa_pkg::CTL_FIFO_IRQ_EN]) ||
      (st_nxt.sf_change && st_r.control[tpa_pkg::CTL_SF_IRQ_EN]));
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      st_r <= '0;
      st_r.indicator_a_low <= tpa_pkg::INDICATOR_A_LOW_RST;
      st_r.indicator_a_high <= tpa_pkg::INDICATOR_A_HIGH_RST;
      st_r.control <= tpa_pkg::CONTROL_RST;
      st_r.status_cfg <= tpa_pkg::STATUS_DIAG_RST;
      st_r.stream_mode <= tpa_pkg::STREAM_MODE_RST;
      st_r.js <= tpa_pkg::JS_NORMAL;
      st_r.frame_cnt <= tpa_pkg::FRAME_CNT_RST;
      st_r.ptr <= tpa_pkg::PTR_RST;
      st_r.irq_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_apb = st_r.apb;
  assign o_tx = st_r.tx;
  assign o_interrupt_out_n = st_r.irq_n;

endmodule // tpa_aligner

// file: tpa_pkg.sv
// constants, types and decode helpers for the transmit pointer aligner
// assumes a 100 MHz reference clock and an apb master with 32-bit data
package tpa_pkg;

  localparam int DATA_W = 8;
  localparam int APB_AW = 12;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;
  localparam logic [5:0] FIFO_FULL = 6'h20;
  localparam logic [5:0] FIFO_CENTRE = 6'h10;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_INDICATOR_A_LOW = 8'h3E;
  localparam logic [7:0] IDX_INDICATOR_A_HIGH = 8'h3F;
  localparam logic [7:0] IDX_CONTROL = 8'h40;
  localparam logic [7:0] IDX_STATUS_DIAG = 8'h41;
  localparam logic [7:0] IDX_SIGNAL_FAIL = 8'h42;
  localparam logic [7:0] IDX_STREAM_MODE = 8'h43;

  localparam logic [7:0] INDICATOR_A_LOW_RST = 8'hFF;
  localparam logic [7:0] INDICATOR_A_HIGH_RST = 8'h93;
  localparam logic [7:0] CONTROL_RST = 8'h10;
  localparam logic [7:0] STATUS_DIAG_RST = 8'h20;
  localparam logic [7:0] STATUS_DIAG_RW_MASK = 8'hF1;
  localparam logic [1:0] STREAM_MODE_RST = 2'h0;

  // aligner control bit positions
  localparam int CTL_PJ_IRQ_EN = 1;
  localparam int CTL_FIFO_IRQ_EN = 2;
  localparam int CTL_SF_IRQ_EN = 3;
  localparam int CTL_CLEAR_STUFF = 5;
  localparam int CTL_MF_BYPASS = 6;
  // status and diagnostic bit positions
  localparam int STS_NEG_JUST = 1;
  localparam int STS_POS_JUST = 2;
  localparam int STS_FIFO_ERR = 3;
  localparam int STS_DEPTH_LSB = 4;
  localparam int STS_DIAG_LSB = 6;
  // signal fail register bit positions
  localparam int SF_CHANGE = 6;
  localparam int SF_STATE = 7;

  localparam logic [7:0] H4_SEQ_BASE = 8'hFC;
  localparam logic [3:0] PTR_NDF_NORMAL = 4'h6;
  localparam logic [9:0] PTR_RST = 10'h000;
  localparam logic [9:0] PTR_MAX = 10'h30E;
  localparam logic [9:0] PTR_I_MASK = 10'h2AA;
  localparam logic [9:0] PTR_D_MASK = 10'h155;
  localparam logic [3:0] ISF_CODE = 4'hE;
  localparam logic [3:0] FRAME_CNT_RST = 4'h0;

  typedef enum logic [3:0] {
    SLOT_TOH = 4'h0, SLOT_H1 = 4'h1, SLOT_H2 = 4'h2, SLOT_H3 = 4'h3,
    SLOT_PAYLOAD = 4'h4, SLOT_PJO = 4'h5, SLOT_H4 = 4'h6, SLOT_FSTUFF = 4'h7,
    SLOT_Z5 = 4'h8
  } tpa_slot_t;

  typedef enum logic [1:0] {
    MODE_STS1 = 2'h0, MODE_STS3 = 2'h1, MODE_STS3C = 2'h2
  } tpa_mode_t;

  typedef enum logic [1:0] {
    DIAG_AUTO = 2'h0, DIAG_NEG = 2'h1, DIAG_POS = 2'h2, DIAG_NONE = 2'h3
  } tpa_diag_t;

  typedef enum logic [1:0] {
    JS_NORMAL = 2'h0, JS_JUST = 2'h1, JS_SETTLE = 2'h3, JS_COOL = 2'h2
  } tpa_js_t;

  typedef struct packed {
    logic [7:0] data;
    tpa_slot_t slot;
    logic marker;
  } tpa_add_bus_t;

  typedef struct packed {
    logic valid;
    tpa_slot_t slot;
    logic [1:0] sts;
  } tpa_tx_slot_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } tpa_tx_out_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } tpa_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tpa_apb_rsp_t;

  typedef struct packed {
    logic is_v1;
    logic is_h4;
    logic is_fstuff;
    logic [7:0] data;
  } tpa_fifo_word_t;

  typedef struct packed {
    logic [2:0] hard_neg;
    logic [2:0] soft_neg;
    logic [2:0] soft_pos;
    logic [2:0] hard_pos;
  } tpa_limits_t;

  function automatic tpa_limits_t tpa_limits(input logic [1:0] code);
    unique case (code)
      2'h0: tpa_limits = '{3'h4, 3'h0, 3'h0, 3'h4};
      2'h1: tpa_limits = '{3'h5, 3'h1, 3'h1, 3'h4};
      2'h2: tpa_limits = '{3'h6, 3'h4, 3'h4, 3'h6};
      2'h3: tpa_limits = '{3'h7, 3'h6, 3'h6, 3'h7};
    endcase
  endfunction

  function automatic logic tpa_carries_payload(input tpa_slot_t slot);
    tpa_carries_payload = (slot == SLOT_PAYLOAD) || (slot == SLOT_H4) ||
                          (slot == SLOT_FSTUFF) || (slot == SLOT_Z5);
  endfunction

endpackage

// file: tpa_fifo.sv
// elastic store of tagged payload bytes for the transmit pointer aligner
// assumes push and pop both come from the reference clock domain
`timescale 1ns/100ps
module tpa_fifo (
  input logic i_ref_clk,
  input logic i_resetn,
  input logic i_push,
  input tpa_pkg::tpa_fifo_word_t i_wdata,
  input logic i_pop,
  output tpa_pkg::tpa_fifo_word_t o_rdata,
  output logic [5:0] o_fill
);

  typedef struct packed {
    tpa_pkg::tpa_fifo_word_t [tpa_pkg::FIFO_DEPTH-1:0] mem;
    logic [tpa_pkg::FIFO_AW-1:0] wr_ptr;
    logic [tpa_pkg::FIFO_AW-1:0] rd_ptr;
    logic [5:0] fill;
  } tpa_fifo_st_t;

  tpa_fifo_st_t st_r;
  tpa_fifo_st_t st_nxt;
  logic do_push;
  logic do_pop;

  // a push into a full store and a pop from an empty one are dropped
  assign do_push = i_push && (st_r.fill != tpa_pkg::FIFO_FULL);
  assign do_pop = i_pop && (st_r.fill != 6'h00);

  always_comb begin
    st_nxt = st_r;
    if (do_push) begin
      st_nxt.mem[st_r.wr_ptr] = i_wdata;
      st_nxt.wr_ptr = st_r.wr_ptr + 5'h01;
    end
    if (do_pop) begin
      st_nxt.rd_ptr = st_r.rd_ptr + 5'h01;
    end
    unique case ({do_push, do_pop})
      2'b10: st_nxt.fill = st_r.fill + 6'h01;
      2'b01: st_nxt.fill = st_r.fill - 6'h01;
      default: st_nxt.fill = st_r.fill;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata = st_r.mem[st_r.rd_ptr];
  assign o_fill = st_r.fill;

endmodule // tpa_fifo

// file: tpa_aligner_asserts.sv
// concurrent checks on the transmit pointer aligner ports
// assumes one reference clock domain; apb writes land at the pready edge
`timescale 1ns/100ps
module tpa_aligner_asserts (
  input logic i_ref_clk,
  input logic i_resetn,
  input tpa_pkg::tpa_apb_req_t i_apb,
  input tpa_pkg::tpa_apb_rsp_t o_apb,
  input logic i_add_clk,
  input tpa_pkg::tpa_add_bus_t i_add_bus,
  input tpa_pkg::tpa_tx_slot_t i_tx_slot,
  input tpa_pkg::tpa_tx_out_t o_tx,
  input logic o_interrupt_out_n
);
  logic setup;
  logic mapped;
  logic wr;
  logic [7:0] chi_r;
  logic [7:0] clo_r;
  logic [1:0] mode_r;
  logic clr_r;
  assign setup = i_apb.psel && !i_apb.penable;
  assign mapped = i_apb.paddr[11:2] inside {[10'h03E:10'h043]};
  assign wr = o_apb.pready && i_apb.penable && i_apb.pwrite;
  // shadow of the settings that steer the byte rewrite
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      {chi_r, clo_r, mode_r, clr_r} <= {8'h93, 8'hFF, 2'h0, 1'b0};
    end else if (wr) begin
      case (i_apb.paddr[11:2])
        10'h03E: clo_r <= i_apb.pwdata[7:0];
        10'h03F: chi_r <= i_apb.pwdata[7:0];
        10'h040: clr_r <= i_apb.pwdata[5];
        10'h043: mode_r <= i_apb.pwdata[1:0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  AST_SETUP_READY: assert property (setup |=> o_apb.pready)
    else $error("no pready after setup");
  AST_READY_PULSE: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("pready longer than one cycle");
  AST_REFUSE: assert property (setup && !mapped |=> o_apb.pslverr && o_apb.prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (setup && mapped |=> !o_apb.pslverr)
    else $error("mapped access refused");
  AST_IDLE_BUS: assert property (!o_apb.pready |-> o_apb.prdata == 32'h0 && !o_apb.pslverr)
    else $error("read bus not idle");
  AST_TX_ECHO: assert property (i_tx_slot.valid |=> o_tx.valid)
    else $error("transmit byte missing");
  AST_TX_QUIET: assert property (!i_tx_slot.valid |=> !o_tx.valid)
    else $error("spurious transmit byte");
  AST_H1_FIXED: assert property (i_tx_slot.valid && i_tx_slot.slot == tpa_pkg::SLOT_H1 &&
    i_tx_slot.sts == 2'h0 |=> o_tx.data[7:2] == 6'h18) else $error("bad h1 flag bits");
  AST_CLEAR_STUFF: assert property (i_tx_slot.valid && i_tx_slot.slot == tpa_pkg::SLOT_FSTUFF &&
    clr_r |=> o_tx.data == 8'h00) else $error("stuff byte not cleared");
  AST_INDICATOR_A_H1: assert property (i_tx_slot.valid && i_tx_slot.slot == tpa_pkg::SLOT_H1 &&
    i_tx_slot.sts != 2'h0 && mode_r == 2'h2 |=> o_tx.data == $past(chi_r))
    else $error("wrong h1 indicator_a byte");
  AST_INDICATOR_A_H2: assert property (i_tx_slot.valid && i_tx_slot.slot == tpa_pkg::SLOT_H2 &&
    i_tx_slot.sts != 2'h0 && mode_r == 2'h2 |=> o_tx.data == $past(clo_r))
    else $error("wrong h2 indicator_a byte");
endmodule // tpa_aligner_asserts
bind tpa_aligner tpa_aligner_asserts u_asserts (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
  .i_apb(i_apb), .o_apb(o_apb), .i_add_clk(i_add_clk), .i_add_bus(i_add_bus),
  .i_tx_slot(i_tx_slot), .o_tx(o_tx), .o_interrupt_out_n(o_interrupt_out_n));

// file: tpa_add_model.sv
// add bus source: repeating twelve-slot frame, v1 marked every fourth h4
// assumes the aligner captures on the falling add clock edge
`timescale 1ns/100ps
module tpa_add_model (
  input logic i_hold,
  output logic o_add_clk,
  output tpa_pkg::tpa_add_bus_t o_add_bus
);
  // the byte after h3 carries payload upstream, so five bytes a frame are
  // stored, matching the five that the transmit side reads
  logic [3:0] seq [12] = '{4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h4, 4'h8};
  // starting one slot ahead lets each byte land before its transmit slot,
  // so the store's first read lines up with the frame
  int k = 1;
  logic [1:0] ph = 2'h0;
  logic [7:0] cnt = 8'h00;
  initial begin
    o_add_clk = 1'b0;
    o_add_bus = '0;
    #3;
    // a hold parks the clock low so the store starves
    forever #80 if (!i_hold || o_add_clk) o_add_clk = !o_add_clk;
  end
  always @(posedge o_add_clk) begin
    o_add_bus.slot <= tpa_pkg::tpa_slot_t'(seq[k]);
    o_add_bus.marker <= (seq[k] == 4'h6) && (ph == 2'h0);
    // z5 kept at zero so no signal fail code is ever sent
    o_add_bus.data <= (seq[k] == 4'h6) ? {6'h10, ph} : (seq[k] == 4'h8) ? 8'h00 : cnt;
    cnt <= cnt + 8'h01;
    if (seq[k] == 4'h6) ph <= ph + 2'h1;
    k <= (k == 11) ? 0 : k + 1;
  end
endmodule // tpa_add_model

// file: test_tpa_aligner.sv
// self-checking bench for the transmit pointer aligner
// assumes the bound checker and the add bus source model
`timescale 1ns/100ps
module test_tpa_aligner;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hold = 1'b0;
  logic add_clk;
  tpa_pkg::tpa_add_bus_t add_bus;
  tpa_pkg::tpa_apb_req_t req = '0;
  tpa_pkg::tpa_apb_rsp_t rsp;
  tpa_pkg::tpa_tx_slot_t tx = '0;
  tpa_pkg::tpa_tx_out_t txo;
  logic irq_n;
  logic [3:0] seq [12] = '{4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h4, 4'h8};
  logic [11:0] adr [6] = '{12'h0F8, 12'h0FC, 12'h100, 12'h104, 12'h108, 12'h10C};
  logic [7:0] rst [6] = '{8'hFF, 8'h93, 8'h10, 8'h20, 8'h00, 8'h00};
  logic [3:0] pend = 4'h0;
  logic [7:0] h4;
  logic [7:0] fs;
  logic [7:0] q;
  logic [7:0] r;
  logic err;
  logic [1:0] ph;
  int tc = 0;
  int tk = 0;
  int h4_cnt = 0;
  int cycles = 0;
  int num_errors = 0;
  int total_checks = 0;
  int seed = 32'h781004e2;
  always #5 clk = !clk;
  tpa_add_model u_src (.i_hold(hold), .o_add_clk(add_clk), .o_add_bus(add_bus));
  tpa_aligner DUT (.i_ref_clk(clk), .i_resetn(rstn), .i_apb(req), .o_apb(rsp),
    .i_add_clk(add_clk), .i_add_bus(add_bus), .i_tx_slot(tx), .o_tx(txo),
    .o_interrupt_out_n(irq_n));
  function automatic logic [1:0] sts_of(input int i);
    return (i < 3) ? 2'(i) : (i < 6) ? 2'(i - 3) : 2'h0;
  endfunction
  function automatic logic [7:0] h4_after(input logic [1:0] p);
    return 8'hFC | {6'h00, p + 2'h1};
  endfunction
  task results;
    if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge clk) req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    q = rsp.prdata[7:0];
    err = rsp.pslverr;
    req <= '0;
  endtask
  task frames(input int n);
    repeat (n * 192) @(posedge clk);
  endtask
  task wait_h4;
    int c;
    c = h4_cnt;
    while (h4_cnt == c) @(posedge clk);
  endtask
  // one transmit slot every 16 cycles matches the 160 ns add byte rate
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
    tc <= (tc == 15) ? 0 : tc + 1;
    if (tc == 15) tk <= (tk == 11) ? 0 : tk + 1;
    tx <= (tc == 15 && rstn) ?
          tpa_pkg::tpa_tx_slot_t'{1'b1, tpa_pkg::tpa_slot_t'(seq[tk]), sts_of(tk)} : '0;
    if (tx.valid) pend <= tx.slot;
  end
  always @(negedge clk) if (txo.valid === 1'b1) begin
    if (pend == 4'h6) begin
      h4 = txo.data;
      h4_cnt++;
    end
    if (pend == 4'h7) fs = txo.data;
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, adr[i], 8'h00);
      check(q, rst[i]);
    end
    apb(1'b0, 12'h200, 8'h00);
    check({err, q[6:0]}, 8'h80);
    for (int i = 0; i < 2; i++) begin
      r = 8'($random(seed));
      apb(1'b1, adr[i], r);
      apb(1'b0, adr[i], 8'h00);
      check(q, r);
    end
    apb(1'b1, 12'h10C, 8'h02);
    apb(1'b1, 12'h104, 8'hE0);
    apb(1'b1, 12'h100, 8'h50);
    frames(6);
    wait_h4;
    wait_h4;
    ph = h4[1:0];
    check({h4[7:2], 2'h0}, 8'h40);
    apb(1'b1, 12'h100, 8'h10);
    wait_h4;
    check(h4, h4_after(ph));
    wait_h4;
    check(h4, h4_after(ph + 2'h1));
    apb(1'b1, 12'h100, 8'h30);
    wait_h4;
    wait_h4;
    check(fs, 8'h00);
    apb(1'b1, 12'h100, 8'h12);
    apb(1'b0, 12'h104, 8'h00);
    apb(1'b1, 12'h104, 8'hA0);
    frames(6);
    check({7'h0, irq_n}, 8'h00);
    apb(1'b1, 12'h104, 8'hE0);
    apb(1'b0, 12'h104, 8'h00);
    check({4'h0, q[3:1], 1'b0}, 8'h04);
    repeat (3) @(negedge clk);
    check({7'h0, irq_n}, 8'h01);
    frames(6);
    apb(1'b0, 12'h104, 8'h00);
    check({4'h0, q[3:1], 1'b0}, 8'h00);
    apb(1'b1, 12'h100, 8'h10);
    apb(1'b1, 12'h104, 8'h60);
    frames(6);
    check({7'h0, irq_n}, 8'h01);
    apb(1'b1, 12'h104, 8'hE0);
    apb(1'b0, 12'h104, 8'h00);
    check({4'h0, q[3:1], 1'b0}, 8'h02);
    apb(1'b1, 12'h100, 8'h14);
    apb(1'b1, 12'h104, {2'h0, 2'($random(seed)), 4'h0});
    apb(1'b0, 12'h104, 8'h00);
    hold <= 1'b1;
    frames(6);
    check({7'h0, irq_n}, 8'h00);
    apb(1'b0, 12'h104, 8'h00);
    check({7'h0, q[3]}, 8'h01);
    hold <= 1'b0;
    results();
  end
endmodule // test_tpa_aligner
